// file: design/lp2_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
interface lp2_bus_if;
    // command/address, one rising and one falling half
    logic [lp2_cmd_pkg::CA_W-1:0] ca_r;
    logic [lp2_cmd_pkg::CA_W-1:0] ca_f;
    logic                         cs_n;
    logic                         cke;
    // controller signals that the clock is halted
    logic                         ck_stop;
    // mode register read data, first beat
    logic [7:0]                   dq;
    logic                         dq_valid;
    modport ctrl (output ca_r, ca_f, cs_n, cke, ck_stop, input dq, dq_valid);
    modport dev  (input ca_r, ca_f, cs_n, cke, ck_stop, output dq, dq_valid);
endinterface : lp2_bus_if
`default_nettype wire

// file: design/lp2_cmd_pkg.sv
package lp2_cmd_pkg;
    // command/address bus width
    localparam int CA_W = 10;
    // mode register address and data widths
    localparam int MA_W = 8;
    localparam int OP_W = 8;
    // clock rate in MHz, period 8 ns
    localparam int CLK_MHZ = 125;
    // timing figures in ns, counts derived by rounding
    localparam int T_RP_NS   = 18;
    localparam int T_RFC_NS  = 130;
    localparam int T_CKE_NS  = 24;
    localparam int T_REFI_NS = 3900;
    localparam int RP_CYC    = (T_RP_NS * CLK_MHZ + 999) / 1000;
    localparam int RFC_CYC   = (T_RFC_NS * CLK_MHZ + 999) / 1000;
    localparam int CKE_CYC   = (T_CKE_NS * CLK_MHZ + 999) / 1000;
    localparam int REFI_CYC  = (T_REFI_NS * CLK_MHZ) / 1000;
    // command periods in clocks
    localparam int MRR_CYC   = 2;
    localparam int MRW_CYC   = 5;
    localparam int CLKSTP_CYC = 2;
    // posting limit and burst length of a mode register read
    localparam int POST_MAX  = 8;
    localparam int MRR_BL    = 4;
    // latencies in clocks
    localparam int RL_DEF    = 3;
    localparam int WL_DEF    = 1;
    // reset write address
    localparam logic [7:0] MA_RESET = 8'h3F;
    // controller request codes
    typedef enum logic [2:0] {
        REQ_NONE = 3'h0,
        REQ_REF  = 3'h1,
        REQ_MRR  = 3'h2,
        REQ_MRW  = 3'h3,
        REQ_BST  = 3'h4,
        REQ_SREF = 3'h5,
        REQ_PD   = 3'h6,
        REQ_DPD  = 3'h7
    } req_t;
    // decoded command on the device side
    typedef enum logic [3:0] {
        CMD_NOP  = 4'h0,
        CMD_DESL = 4'h1,
        CMD_BST  = 4'h2,
        CMD_REFA = 4'h3,
        CMD_REFB = 4'h4,
        CMD_MRR  = 4'h5,
        CMD_MRW  = 4'h6,
        CMD_OTHR = 4'h7
    } cmd_t;
    // device power states, gray along the usual path
    typedef enum logic [2:0] {
        PS_IDLE = 3'b000,
        PS_PD   = 3'b001,
        PS_SREF = 3'b011,
        PS_DPD  = 3'b010,
        PS_INIT = 3'b110
    } pstate_t;
endpackage : lp2_cmd_pkg

// file: design/lp2_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// controller end: issues one request at a time, keeps spacing
module lp2_ctrl (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // link to device
    lp2_bus_if.ctrl          bus,
    // user request
    input  wire logic        i_req_valid,
    input  wire logic [2:0]  i_req_code,
    input  wire logic [7:0]  i_req_ma,
    input  wire logic [6:0]  i_req_op,
    input  wire logic        i_exit,
    input  wire logic        i_ck_stop,
    output logic             o_req_ready,
    // read result and status
    output logic [7:0]       o_rd_data,
    output logic             o_rd_valid,
    output logic [3:0]       o_posted,
    output logic             o_low_power
);
    logic        wait_done;   // spacing timer idle
    logic        load;        // start spacing
    logic [15:0] gap;         // spacing to load
    logic        lowp;        // cke held low
    logic        need_ref;    // extra refresh owed after self-refresh
    logic [15:0] refi_cnt;    // refresh interval timer
    logic [3:0]  posted;      // refreshes owed
    logic        is_sref;
    logic        force_ref;   // posting limit or power-down/self-refresh entry pending
    logic        go;
    lp2_cmd_pkg::req_t code;

    assign code = lp2_cmd_pkg::req_t'(i_req_code);
    // while refreshes are owed, one is forced before power-down or self-refresh entry (not deep power-down) or at the limit
    assign force_ref = posted != 4'h0 && (posted >= 4'(lp2_cmd_pkg::POST_MAX)
                       || (i_req_valid && code inside {lp2_cmd_pkg::REQ_SREF, lp2_cmd_pkg::REQ_PD}));
    assign o_req_ready = wait_done && !lowp && !bus.ck_stop && !force_ref
                         && !(code == lp2_cmd_pkg::REQ_SREF && need_ref);
    assign go = i_req_valid && o_req_ready;

    lp2_down_cnt #(.W(16)) u_gap (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_load    (load),
        .i_val     (gap),
        .o_done    (wait_done)
    );

    // spacing after each command
    always_comb begin
        load = 1'b0;
        gap  = '0;
        if (wait_done && !lowp && force_ref) begin
            load = 1'b1;
            gap  = 16'(lp2_cmd_pkg::RFC_CYC);
        end else if (go) begin
            load = 1'b1;
            unique case (code)
                lp2_cmd_pkg::REQ_MRR: gap = 16'(lp2_cmd_pkg::MRR_CYC);
                lp2_cmd_pkg::REQ_MRW: gap = 16'(lp2_cmd_pkg::MRW_CYC);
                lp2_cmd_pkg::REQ_REF: gap = 16'(lp2_cmd_pkg::RFC_CYC);
                lp2_cmd_pkg::REQ_PD, lp2_cmd_pkg::REQ_SREF, lp2_cmd_pkg::REQ_DPD:
                    gap = 16'(lp2_cmd_pkg::CKE_CYC);
                default: gap = 16'h0001;
            endcase
        end else if (lowp && i_exit && wait_done) begin
            load = 1'b1;
            gap  = 16'(lp2_cmd_pkg::CKE_CYC);
        end
    end

    // drive the command bus; idle is nop with cke high
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            bus.cs_n <= 1'b1;
            bus.ca_r <= '0;
            bus.ca_f <= '0;
            bus.cke  <= 1'b1;
            lowp     <= 1'b0;
            is_sref  <= 1'b0;
        end else begin
            bus.cs_n <= 1'b0;
            bus.ca_r <= 10'h007;
            bus.ca_f <= '0;
            if (wait_done && !lowp && force_ref) begin
                bus.ca_r <= 10'h00C;
            end else if (go) begin
                unique case (code)
                    // no precharge is ever sent, so banks sit idle past tRP
                    lp2_cmd_pkg::REQ_REF:  bus.ca_r <= 10'h00C;
                    lp2_cmd_pkg::REQ_MRR: begin
                        bus.ca_r <= {i_req_ma[5:0], 4'h8};
                        bus.ca_f <= {8'h00, i_req_ma[7:6]};
                    end
                    lp2_cmd_pkg::REQ_MRW: begin
                        bus.ca_r <= {i_req_ma[5:0], 4'h0};
                        bus.ca_f <= {i_req_op, 1'b0, i_req_ma[7:6]};
                    end
                    lp2_cmd_pkg::REQ_BST:  bus.ca_r <= 10'h003;
                    lp2_cmd_pkg::REQ_SREF: begin
                        bus.ca_r <= 10'h004;
                        bus.cke  <= 1'b0;
                        lowp     <= 1'b1;
                        is_sref  <= 1'b1;
                    end
                    lp2_cmd_pkg::REQ_PD: begin
                        bus.cs_n <= 1'b1;
                        bus.cke  <= 1'b0;
                        lowp     <= 1'b1;
                        is_sref  <= 1'b0;
                    end
                    lp2_cmd_pkg::REQ_DPD: begin
                        bus.ca_r <= 10'h003;
                        bus.cke  <= 1'b0;
                        lowp     <= 1'b1;
                        is_sref  <= 1'b0;
                    end
                    default: bus.ca_r <= 10'h007;
                endcase
            end else if (lowp && i_exit && wait_done && !bus.ck_stop) begin
                bus.cke <= 1'b1;
                lowp    <= 1'b0;
            end
        end
    end

    // clock halt only while low, restart before exit
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            bus.ck_stop <= 1'b0;
        end else begin
            // never halted with cke high, so no restart nop is owed
            bus.ck_stop <= i_ck_stop && lowp && wait_done && !i_exit;
        end
    end

    // posted refresh bookkeeping and self-refresh debt
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            refi_cnt <= '0;
            posted   <= '0;
            need_ref <= 1'b0;
        end else begin
            refi_cnt <= (refi_cnt == 16'(lp2_cmd_pkg::REFI_CYC - 1)) ? 16'h0000 : refi_cnt + 16'h0001;
            if ((refi_cnt == 16'(lp2_cmd_pkg::REFI_CYC - 1)) && !is_sref_low()) begin
                if (!(bus.ca_r == 10'h00C && !bus.cs_n) && posted != 4'hF) posted <= posted + 4'h1;
            end else if (bus.ca_r == 10'h00C && !bus.cs_n && bus.cke && posted != 4'h0) begin
                posted <= posted - 4'h1;
            end
            if (lowp && is_sref && i_exit && wait_done) need_ref <= 1'b1;
            else if (bus.ca_r == 10'h00C && !bus.cs_n) need_ref <= 1'b0;
        end
    end
    function automatic logic is_sref_low();
        return lowp && is_sref;
    endfunction : is_sref_low

    // capture the mode read first beat
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data  <= '0;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= bus.dq_valid;
            if (bus.dq_valid) o_rd_data <= bus.dq;
        end
    end
    assign o_posted    = posted;
    assign o_low_power = lowp;
endmodule : lp2_ctrl
`default_nettype wire

// file: design/lp2_dev.sv
`timescale 1ns/10ps
`default_nettype none
module lp2_dev #(
    parameter int RL = lp2_cmd_pkg::RL_DEF,
    parameter int WL = lp2_cmd_pkg::WL_DEF
) (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    // link to controller
    lp2_bus_if.dev          bus,
    // access burst from the unmodelled read/write path
    input  wire logic       i_acc_start,
    input  wire logic       i_acc_is_rd,
    // status
    output logic [2:0]      o_pstate,
    output logic            o_burst_stop,
    output logic            o_int_ref,
    output logic            o_reinit_req,
    output logic [7:0]      o_mr_addr,
    output logic [7:0]      o_mr_data,
    output logic            o_mr_wr
);
    lp2_cmd_pkg::pstate_t ps;        // power state
    lp2_cmd_pkg::cmd_t    cmd;       // decoded command
    logic                 cke_q;     // cke of the previous cycle
    logic [7:0]           mr [256];  // mode registers
    logic [7:0]           ma;        // address from both edges
    logic [15:0]          acc_age;   // clocks since latest access
    logic                 acc_rd;    // latest access was a read
    logic [7:0]           stop_cnt;  // latency countdown to cut
    logic                 stop_arm;
    logic [7:0]           rd_pipe;   // mode read latency shift
    logic [7:0]           rd_val;    // data held for the beat
    logic [7:0]           sr_cnt;    // self-refresh internal timer
    logic [7:0]           bank_ref;  // internal bank counter
    logic                 ref_busy;  // refresh in progress

    // command decode from the rising half
    always_comb begin
        if (bus.cs_n) begin
            cmd = lp2_cmd_pkg::CMD_DESL;
        end else if (bus.ca_r[2:0] == 3'h7) begin
            cmd = lp2_cmd_pkg::CMD_NOP;
        end else if (bus.ca_r[3:0] == 4'h3) begin
            cmd = lp2_cmd_pkg::CMD_BST;
        end else if (bus.ca_r[2:0] == 3'h4) begin
            cmd = bus.ca_r[3] ? lp2_cmd_pkg::CMD_REFA : lp2_cmd_pkg::CMD_REFB;
        end else if (bus.ca_r[3:0] == 4'h8) begin
            cmd = lp2_cmd_pkg::CMD_MRR;
        end else if (bus.ca_r[3:0] == 4'h0) begin
            cmd = lp2_cmd_pkg::CMD_MRW;
        end else begin
            cmd = lp2_cmd_pkg::CMD_OTHR;
        end
    end
    // mode register address: falling CA1..0 then rising CA9..4
    assign ma = {bus.ca_f[1:0], bus.ca_r[9:4]};

    // previous cke
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cke_q <= 1'b0;
        end else begin
            cke_q <= bus.cke;
        end
    end

    // power state; only cke is looked at in power-down, self-refresh and deep power-down
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ps <= lp2_cmd_pkg::PS_IDLE;
        end else begin
            unique case (ps)
                lp2_cmd_pkg::PS_IDLE: begin
                    if (cke_q && !bus.cke) begin
                        if (bus.cs_n) begin
                            ps <= lp2_cmd_pkg::PS_PD;
                        end else if (bus.ca_r[2:0] == 3'h4) begin
                            ps <= lp2_cmd_pkg::PS_SREF;
                        end else if (bus.ca_r[2:0] == 3'h3) begin
                            ps <= lp2_cmd_pkg::PS_DPD;
                        end
                    end else if (bus.cke && cmd == lp2_cmd_pkg::CMD_MRW && ma == lp2_cmd_pkg::MA_RESET) begin
                        ps <= lp2_cmd_pkg::PS_INIT;
                    end
                end
                // exit as soon as cke is high; the command on the bus is not looked at
                lp2_cmd_pkg::PS_PD: if (bus.cke) ps <= lp2_cmd_pkg::PS_IDLE;
                lp2_cmd_pkg::PS_SREF: if (bus.cke) ps <= lp2_cmd_pkg::PS_IDLE;
                // contents lost, init needed on exit
                lp2_cmd_pkg::PS_DPD: if (bus.cke) ps <= lp2_cmd_pkg::PS_INIT;
                // init leaves to idle on the first nop; deselect or any other command keeps it
                lp2_cmd_pkg::PS_INIT: if (cmd == lp2_cmd_pkg::CMD_NOP) ps <= lp2_cmd_pkg::PS_IDLE;
                default: ps <= lp2_cmd_pkg::PS_IDLE;
            endcase
        end
    end
    assign o_pstate = ps;
    assign o_reinit_req = (ps == lp2_cmd_pkg::PS_INIT);

    // latest access age; bst only needs it non-zero
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            acc_age <= '0;
            acc_rd  <= 1'b0;
        end else if (i_acc_start) begin
            acc_age <= 16'h0001;
            acc_rd  <= i_acc_is_rd;
        end else if (acc_age != '0 && acc_age != 16'hFFFF) begin
            acc_age <= acc_age + 16'h0001;
        end
    end

    // terminate: cut after rl or wl; nop/deselect leave it running
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            stop_cnt <= '0;
            stop_arm <= 1'b0;
        end else if (ps == lp2_cmd_pkg::PS_IDLE && bus.cke && cmd == lp2_cmd_pkg::CMD_BST && acc_age != '0) begin
            stop_cnt <= acc_rd ? 8'(RL) : 8'(WL);
            stop_arm <= 1'b1;
        end else if (stop_cnt > 8'h01) begin
            stop_cnt <= stop_cnt - 8'h01;
        end else begin
            stop_arm <= 1'b0;
            stop_cnt <= '0;
        end
    end
    assign o_burst_stop = stop_arm && stop_cnt == 8'h01;

    // mode register write, any mode register including reset
    always_ff @(posedge i_clk_sys) begin
        if (bus.cke && ps != lp2_cmd_pkg::PS_SREF && cmd == lp2_cmd_pkg::CMD_MRW) begin
            mr[ma] <= {1'b0, bus.ca_f[9:3]};
        end
    end
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_mr_addr <= '0;
            o_mr_data <= '0;
            o_mr_wr   <= 1'b0;
        end else begin
            o_mr_wr <= bus.cke && ps != lp2_cmd_pkg::PS_SREF && cmd == lp2_cmd_pkg::CMD_MRW;
            o_mr_addr <= ma;
            o_mr_data <= {1'b0, bus.ca_f[9:3]};
        end
    end

    // mode read: value appears RL clocks on, first beat only
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rd_pipe <= '0;
            rd_val  <= '0;
        end else begin
            rd_pipe <= {rd_pipe[6:0], (ps == lp2_cmd_pkg::PS_IDLE && bus.cke && cmd == lp2_cmd_pkg::CMD_MRR)};
            if (ps == lp2_cmd_pkg::PS_IDLE && bus.cke && cmd == lp2_cmd_pkg::CMD_MRR) begin
                rd_val <= mr[ma];
            end
        end
    end
    assign bus.dq_valid = rd_pipe[RL-1];
    assign bus.dq       = rd_pipe[RL-1] ? rd_val : 8'h00;

    // refresh engine and self-refresh timer
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sr_cnt   <= '0;
            bank_ref <= '0;
            ref_busy <= 1'b0;
        end else begin
            if (ps == lp2_cmd_pkg::PS_SREF) begin
                // first internal refresh well inside tCKE
                sr_cnt <= (sr_cnt >= 8'(lp2_cmd_pkg::REFI_CYC % 256)) ? 8'h00 : sr_cnt + 8'h01;
            end else begin
                sr_cnt <= '0;
            end
            if ((ps == lp2_cmd_pkg::PS_IDLE && bus.cke && cmd == lp2_cmd_pkg::CMD_REFA)
                || (ps == lp2_cmd_pkg::PS_SREF && sr_cnt == 8'h00)) begin
                ref_busy <= 1'b1;
                bank_ref <= 8'h00;
            end else if (ref_busy) begin
                bank_ref <= bank_ref + 8'h01;
                ref_busy <= (bank_ref != 8'h07);
            end
        end
    end
    assign o_int_ref = ref_busy;
endmodule : lp2_dev
`default_nettype wire

// file: design/lp2_down_cnt.sv
`timescale 1ns/10ps
`default_nettype none
// loadable down counter, done while zero
module lp2_down_cnt #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    // load
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_val,
    // status
    output logic              o_done
);
    logic [W-1:0] cnt; // remaining cycles

    // count down, reload has priority
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt <= '0;
        end else if (i_load) begin
            cnt <= i_val;
        end else if (cnt != '0) begin
            cnt <= cnt - W'(1);
        end
    end
    assign o_done = (cnt == '0);
endmodule : lp2_down_cnt
`default_nettype wire

// file: tb/lp2_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// watches the link between controller and device ends
module lp2_link_assertions (
    // clock and reset
    input wire logic       i_clk_sys,
    input wire logic       i_rst,
    // link signals
    input wire logic [9:0] ca_r,
    input wire logic [9:0] ca_f,
    input wire logic       cs_n,
    input wire logic       cke,
    input wire logic       ck_stop,
    input wire logic [7:0] dq,
    input wire logic       dq_valid
);
    // refresh gap window, two short of the refresh cycle count
    localparam int RFC_M2 = lp2_cmd_pkg::RFC_CYC - 2;
    // decoded commands, only meaningful with cke high
    logic is_mrr;
    logic is_mrw;
    logic is_ref;
    logic is_idle;  // nop or deselect
    assign is_mrr  = cke && !cs_n && ca_r[3:0] == 4'h8;
    assign is_mrw  = cke && !cs_n && ca_r[3:0] == 4'h0;
    assign is_ref  = cke && !cs_n && ca_r[2:0] == 3'h4;
    assign is_idle = cs_n || ca_r[2:0] == 3'h7;
    // one clock domain, so one default clocking
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    a_mrr_data_time: assert property (is_mrr |-> ##3 dq_valid)
        else $error("mode read data not on time");
    a_dq_has_cause: assert property (dq_valid |-> $past(is_mrr, 3))
        else $error("read data without a mode read");
    a_mrr_quiet_gap: assert property (is_mrr |=> is_idle && cke)
        else $error("command or cke drop inside mode read period");
    a_mrw_quiet_gap: assert property (is_mrw |=> (is_idle && cke)[*4])
        else $error("command or cke drop inside mode write period");
    a_ref_min_gap: assert property (is_ref |=> not (##[0:RFC_M2] is_ref))
        else $error("refreshes closer than refresh cycle");
    a_cke_low_hold: assert property ($fell(cke) |-> (!cke)[*3])
        else $error("cke low shorter than minimum");
    a_cke_exit_nop: assert property ($rose(cke) |-> is_idle ##1 cke[*2])
        else $error("power exit without nop or short cke high");
    a_low_entry_code: assert property ($fell(cke) && !cs_n |-> ca_r[2:0] == 3'h4 || ca_r[2:0] == 3'h3)
        else $error("cke fall with selected bus is not a low power entry");
    a_clk_stop_wait: assert property ($rose(ck_stop) |-> !cke && !$past(cke) && !$past(cke, 2))
        else $error("clock halted too soon after cke fall");
endmodule : lp2_link_assertions
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// drives both ends from their user sides and checks the effects
module testbench;
    // one row per ordinary request and the effect it should give
    typedef struct {
        lp2_cmd_pkg::req_t code;
        logic [7:0]        ma;
        logic [6:0]        op;
        int                sel;  // which output shows the effect
        logic [2:0]        ps;   // expected power state for sel 4
    } row_t;
    logic              i_clk_sys  = 1'b0;
    logic              i_rst      = 1'b1;
    logic              req_valid  = 1'b0;
    lp2_cmd_pkg::req_t req_code   = lp2_cmd_pkg::REQ_NONE;
    logic [7:0]        req_ma     = 8'h00;
    logic [6:0]        req_op     = 7'h00;
    logic              exit_req   = 1'b0;
    logic              stop_req   = 1'b0;
    logic              acc_start  = 1'b0;
    logic              acc_is_rd  = 1'b0;
    // design outputs
    logic              req_ready, rd_valid, low_power, burst_stop, int_ref, reinit_req, mr_wr;
    logic [7:0]        rd_data, mr_addr, mr_data;
    logic [3:0]        posted;
    logic [2:0]        pstate;
    int                bad_count  = 0;
    int                cmp_count  = 0;
    int                n, n_rd;
    // refresh ahead of each low power entry keeps posting at zero
    row_t rows [12] = '{
        '{lp2_cmd_pkg::REQ_REF,  8'h00, 7'h00, 2, 3'h0},
        '{lp2_cmd_pkg::REQ_MRW,  8'h0A, 7'h55, 0, 3'h0},
        '{lp2_cmd_pkg::REQ_MRR,  8'h0A, 7'h00, 1, 3'h0},
        '{lp2_cmd_pkg::REQ_MRW,  8'hC3, 7'h2A, 0, 3'h0},
        '{lp2_cmd_pkg::REQ_MRR,  8'hC3, 7'h00, 1, 3'h0},
        '{lp2_cmd_pkg::REQ_MRW,  lp2_cmd_pkg::MA_RESET, 7'h00, 5, 3'h0},
        '{lp2_cmd_pkg::REQ_REF,  8'h00, 7'h00, 2, 3'h0},
        '{lp2_cmd_pkg::REQ_PD,   8'h00, 7'h00, 4, 3'h1},
        '{lp2_cmd_pkg::REQ_REF,  8'h00, 7'h00, 2, 3'h0},
        '{lp2_cmd_pkg::REQ_SREF, 8'h00, 7'h00, 4, 3'h3},
        '{lp2_cmd_pkg::REQ_REF,  8'h00, 7'h00, 2, 3'h0},
        '{lp2_cmd_pkg::REQ_DPD,  8'h00, 7'h00, 4, 3'h2}
    };
    // 125 MHz system clock
    always #4 i_clk_sys = ~i_clk_sys;
    lp2_bus_if lp2_bus_if_inst ();
    lp2_ctrl lp2_ctrl_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .bus(lp2_bus_if_inst), .i_req_valid(req_valid),
        .i_req_code(req_code), .i_req_ma(req_ma), .i_req_op(req_op), .i_exit(exit_req), .i_ck_stop(stop_req),
        .o_req_ready(req_ready), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_posted(posted),
        .o_low_power(low_power));
    lp2_dev lp2_dev_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .bus(lp2_bus_if_inst), .i_acc_start(acc_start),
        .i_acc_is_rd(acc_is_rd), .o_pstate(pstate), .o_burst_stop(burst_stop), .o_int_ref(int_ref),
        .o_reinit_req(reinit_req), .o_mr_addr(mr_addr), .o_mr_data(mr_data), .o_mr_wr(mr_wr));
    lp2_link_assertions lp2_link_assertions_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .ca_r(lp2_bus_if_inst.ca_r), .ca_f(lp2_bus_if_inst.ca_f), .cs_n(lp2_bus_if_inst.cs_n),
        .cke(lp2_bus_if_inst.cke), .ck_stop(lp2_bus_if_inst.ck_stop), .dq(lp2_bus_if_inst.dq),
        .dq_valid(lp2_bus_if_inst.dq_valid));
    // prints the counts and the verdict, then ends the run
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    // one comparison, counted
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check
    // selects the output that a wait looks at
    function automatic logic probe(input int sel, input logic [2:0] ps);
        case (sel)
            0: return mr_wr;
            1: return rd_valid;
            2: return int_ref;
            3: return burst_stop;
            5: return reinit_req;
            6: return lp2_bus_if_inst.ck_stop;
            7: return req_ready;
            default: return pstate === ps;
        endcase
    endfunction : probe
    // bounded wait; running out ends the run at once
    task automatic wait_on(input int sel, input logic [2:0] ps, output int cnt);
        cnt = 0;
        while (probe(sel, ps) !== 1'b1 && cnt < 100) begin
            @(posedge i_clk_sys);
            #1;
            cnt++;
        end
        check(cnt < 100, "expected response never came");
        if (cnt >= 100) give_verdict();
    endtask : wait_on
    // holds the request until an edge sees ready high
    task automatic issue(input lp2_cmd_pkg::req_t code, input logic [7:0] ma, input logic [6:0] op);
        // code set before the wait: ready depends on it, so wait only once it stands
        req_valid = 1'b1;
        req_code  = code;
        req_ma    = ma;
        req_op    = op;
        wait_on(7, 3'h0, n);
        @(posedge i_clk_sys);
        #1;
        req_valid = 1'b0;
    endtask : issue
    // reset held four cycles, idle bus expected meanwhile
    task automatic do_reset();
        i_rst = 1'b1;
        repeat (4) @(posedge i_clk_sys);
        #1;
        check(pstate === 3'h0 && lp2_bus_if_inst.cs_n === 1'b1 && lp2_bus_if_inst.cke === 1'b1, "reset state");
        i_rst = 1'b0;
    endtask : do_reset
    // hang guard
    initial begin
        repeat (60000) @(posedge i_clk_sys);
        bad_count++;
        $display("unexpected at %0t: run did not end", $time);
        give_verdict();
    end
    // main sequence
    initial begin
        do_reset();
        foreach (rows[i]) begin
            issue(rows[i].code, rows[i].ma, rows[i].op);
            if (rows[i].sel < 2) check(req_ready === 1'b0, "ready inside spacing period");
            wait_on(rows[i].sel, rows[i].ps, n);
            if (rows[i].sel == 2) check(posted <= 4'(lp2_cmd_pkg::POST_MAX), "posting limit");
            if (rows[i].sel == 0) check(mr_addr === rows[i].ma && mr_data === {1'b0, rows[i].op}, "write");
            if (rows[i].sel == 1) check(rd_data === {1'b0, rows[i - 1].op}, "mode read value");
            if (rows[i].sel == 4) begin
                check(low_power === 1'b1, "low power flag");
                // halt the clock only in plain power-down
                if (rows[i].ps == 3'h1) begin
                    stop_req = 1'b1;
                    wait_on(6, 3'h0, n);
                    stop_req = 1'b0;
                end
                exit_req = 1'b1;
                wait_on(4, 3'h0, n);
                exit_req = 1'b0;
            end
        end
        // second reset while in power-down
        issue(lp2_cmd_pkg::REQ_REF, 8'h00, 7'h00);
        wait_on(2, 3'h0, n);
        issue(lp2_cmd_pkg::REQ_PD, 8'h00, 7'h00);
        wait_on(4, 3'h1, n);
        do_reset();
        // terminated read then write, terminate two clocks after access
        for (int k = 0; k < 2; k++) begin
            acc_is_rd = (k == 0);
            acc_start = 1'b1;
            @(posedge i_clk_sys);
            #1;
            acc_start = 1'b0;
            issue(lp2_cmd_pkg::REQ_BST, 8'h00, 7'h00);
            wait_on(3, 3'h0, n);
            if (k == 0) n_rd = n;
        end
        check(n_rd === lp2_cmd_pkg::RL_DEF && n === lp2_cmd_pkg::WL_DEF, "stop latency");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
